/* File: hdl/spf_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module spf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clr,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_reg, wp_next, rp_reg, rp_next;
    logic push, pop;

    assign in_ready = (wp_reg - rp_reg) != (AW+1)'(DEPTH);
    assign out_valid = wp_reg != rp_reg;
    assign out_data = mem[rp_reg[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wp_next = wp_reg;
        rp_next = rp_reg;
        if (clr) begin
            wp_next = '0;
            rp_next = '0;
        end else begin
            if (push)
                wp_next = wp_reg + 1'b1;
            if (pop)
                rp_next = rp_reg + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
        end
        if (push && !clr)
            mem[wp_reg[AW-1:0]] <= in_data;
    end
endmodule
`default_nettype wire

/* File: hdl/spf_front_end.sv */
// Operation
// - output bits change after each falling serial clock edge
// - input bits are sampled on each rising serial clock edge
// - select high: device deselected, serial output high impedance
// - deselected and idle: standby, not deep power-down
// - select low: device selected, active power mode; code shows active only while reset input is high
// - after power-up, ignore instructions until a select falling edge
// - reset input high: normal operation, instructions accepted
// - reset input low: reset mode, serial output high impedance
// - reset during an internal cycle aborts it; master should avoid it
// - array is 8 Mbit of bytes, byte addressed
// - 16 sectors of 16 subsectors, 256 subsectors total
// - 256 pages per sector, 16 per subsector, 4096 pages total
// - pages are 256 bytes, low address byte picks the byte
// - page write or program takes 1 to 256 data bytes; code drops bytes that arrive while its 32-byte FIFO is full
// - page write erases the addressed page then programs it
// - erase by page, subsector, sector or whole array
// - write protection in 64 Kbyte sector units
// - only protect-level bits and status-write-disable are writable
// - write-in-progress status bit shows a running internal cycle
`timescale 1ns/1ps
`default_nettype none
module spf_front_end #(
    parameter int DEPTH = spf_pkg::FIFO_DEPTH,
    parameter logic [15:0] ID_CODE = 16'h1234
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic sel_b,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic hw_reset_b,
    input wire logic top_lock_n,
    output logic miso_o,
    output logic miso_oe,
    output logic active_mode,
    output logic standby_mode,
    output logic write_in_progress,
    output logic [7:0] status_out,
    output spf_pkg::spf_job_t job,
    output logic job_valid,
    input wire logic job_done,
    output logic [7:0] wdata,
    output logic wdata_valid,
    input wire logic wdata_ready,
    input wire logic [7:0] rdata,
    output logic [spf_pkg::ADDR_W-1:0] raddr
);
    // id code value is arbitrary
    typedef enum logic [2:0] {
        SPF_IDLE, SPF_CMD, SPF_ADDR, SPF_DATA, SPF_OUT, SPF_WAIT
    } spf_state_t;

    spf_pkg::spf_pins_t s1_reg, s2_reg, s3_reg, pin_reg, pin_next;
    logic hr1_reg, hr2_reg, hr3_reg, hr_reg, hr_next;
    spf_state_t st_reg, st_next;
    logic [2:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [1:0] ab_reg, ab_next;
    logic [spf_pkg::ADDR_W-1:0] addr_reg, addr_next;
    logic [8:0] cnt_reg, cnt_next;
    logic [7:0] out_reg, out_next;
    logic [7:0] stat_reg, stat_next;
    logic armed_reg, armed_next;
    logic wen_reg, wen_next;
    logic busy_reg, busy_next;
    logic miso_reg, miso_next, oe_reg, oe_next;
    spf_pkg::spf_job_t job_reg, job_next;
    logic jv_reg, jv_next;
    logic rise, fall, sel_fall, sel_rise, byte_done;
    logic [7:0] byte_in;
    logic f_valid, f_ready, f_clr;
    logic prot_hit, tl_reg, tl_next;
    logic [2:0] tl_sync_reg;
    logic [2:0] bp;

    always_ff @(posedge sys_clk) begin
        s1_reg <= {sel_b, sclk, mosi};
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        hr1_reg <= hw_reset_b;
        hr2_reg <= hr1_reg;
        hr3_reg <= hr2_reg;
        tl_sync_reg <= {tl_sync_reg[1:0], top_lock_n};
    end

    // filtered pin levels update when stages two and three agree
    always_comb begin
        pin_next = pin_reg;
        hr_next = hr_reg;
        tl_next = tl_reg;
        if (s2_reg.sel_b == s3_reg.sel_b)
            pin_next.sel_b = s3_reg.sel_b;
        if (s2_reg.sclk == s3_reg.sclk)
            pin_next.sclk = s3_reg.sclk;
        if (s2_reg.mosi == s3_reg.mosi)
            pin_next.mosi = s3_reg.mosi;
        if (hr2_reg == hr3_reg)
            hr_next = hr3_reg;
        if (tl_sync_reg[1] == tl_sync_reg[2])
            tl_next = tl_sync_reg[2];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pin_reg <= '{sel_b: 1'b0, sclk: 1'b0, mosi: 1'b0};
            hr_reg <= 1'b0;
            tl_reg <= 1'b1;
        end else begin
            pin_reg <= pin_next;
            hr_reg <= hr_next;
            tl_reg <= tl_next;
        end
    end

    assign rise = !pin_reg.sclk && pin_next.sclk && !pin_reg.sel_b;
    assign fall = pin_reg.sclk && !pin_next.sclk && !pin_reg.sel_b;
    assign sel_fall = pin_reg.sel_b && !pin_next.sel_b;
    assign sel_rise = !pin_reg.sel_b && pin_next.sel_b;
    assign byte_in = {sh_reg[6:0], pin_reg.mosi};
    assign byte_done = rise && bit_reg == 3'h7;
    assign bp = stat_reg[4:2];
    // protect the top 2^(bp-1) sectors; bp 5 and above cover all
    assign prot_hit = (!tl_reg && addr_reg[19:16] == 4'hF)
        || bp > 3'h4
        || (bp != 3'h0
        && {1'b0, addr_reg[19:16]} >= 5'h10 - (5'h1 << (bp - 3'h1)));

    spf_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clr(f_clr),
        .in_data(byte_in),
        .in_valid(f_valid),
        .in_ready(f_ready),
        .out_data(wdata),
        .out_valid(wdata_valid),
        .out_ready(wdata_ready)
    );

    always_comb begin
        st_next = st_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        cmd_next = cmd_reg;
        ab_next = ab_reg;
        addr_next = addr_reg;
        cnt_next = cnt_reg;
        out_next = out_reg;
        stat_next = stat_reg;
        armed_next = armed_reg;
        wen_next = wen_reg;
        busy_next = busy_reg;
        miso_next = miso_reg;
        oe_next = oe_reg;
        job_next = job_reg;
        jv_next = 1'b0;
        f_valid = 1'b0;
        f_clr = 1'b0;
        if (busy_reg && job_done)
            busy_next = 1'b0;
        if (rise)
            bit_next = bit_reg + 3'h1;
        if (rise)
            sh_next = byte_in;
        // each output byte loads on its first falling edge
        if (fall && st_reg == SPF_OUT) begin
            out_next = bit_reg == 3'h0 ? (cmd_reg == spf_pkg::OP_READ
                ? rdata : stat_reg) : out_reg;
            miso_next = out_next[7];
            out_next = {out_next[6:0], 1'b0};
            if (bit_reg == 3'h0 && cmd_reg == spf_pkg::OP_READ)
                addr_next = addr_reg + 20'h1;
        end
        if (sel_fall) begin
            armed_next = 1'b1;
            st_next = SPF_CMD;
            bit_next = spf_pkg::BIT_CNT_RST;
            ab_next = 2'h0;
            cnt_next = 9'h0;
            f_clr = !busy_reg;
        end
        case (st_reg)
            SPF_CMD: begin
                if (byte_done) begin
                    cmd_next = byte_in;
                    st_next = SPF_WAIT;
                    case (byte_in)
                        spf_pkg::OP_WRITE_EN: wen_next = 1'b1;
                        spf_pkg::OP_READ_STATUS: st_next = SPF_OUT;
                        spf_pkg::OP_STATUS_WRITE:
                            st_next = (wen_reg && !busy_reg)
                                ? SPF_DATA : SPF_WAIT;
                        spf_pkg::OP_BULK_ERASE: ;
                        default: st_next = SPF_ADDR;
                    endcase
                    if (busy_reg && byte_in != spf_pkg::OP_READ_STATUS)
                        st_next = SPF_WAIT;
                end
            end
            SPF_ADDR: begin
                if (byte_done) begin
                    addr_next = {addr_reg[11:0], byte_in};
                    ab_next = ab_reg + 2'h1;
                    if (ab_reg + 2'h1 == spf_pkg::ADDR_BYTES) begin
                        st_next = cmd_reg == spf_pkg::OP_READ
                            ? SPF_OUT : SPF_DATA;
                    end
                end
            end
            SPF_DATA: begin
                if (byte_done) begin
                    if (cmd_reg == spf_pkg::OP_STATUS_WRITE) begin
                        stat_next = (stat_reg & ~spf_pkg::STATUS_WR_MASK)
                            | (byte_in & spf_pkg::STATUS_WR_MASK);
                        st_next = SPF_WAIT;
                    end else if (cnt_reg < 9'(spf_pkg::PAGE_BYTES)) begin
                        f_valid = f_ready;
                        cnt_next = cnt_reg + {8'h0, f_ready};
                    end
                end
            end
            SPF_IDLE, SPF_OUT, SPF_WAIT: ;
            default: st_next = SPF_IDLE;
        endcase
        if (st_next == SPF_OUT && st_reg != SPF_OUT)
            oe_next = 1'b1;
        if (sel_rise) begin
            oe_next = 1'b0;
            st_next = SPF_IDLE;
            if (st_reg == SPF_DATA || st_reg == SPF_WAIT
                || st_reg == SPF_ADDR) begin
                job_next.addr = addr_reg;
                job_next.count = cnt_reg;
                case (cmd_reg)
                    spf_pkg::OP_PAGE_WRITE:
                        job_next.op = spf_pkg::SPF_OP_PW;
                    spf_pkg::OP_PAGE_PROGRAM:
                        job_next.op = spf_pkg::SPF_OP_PP;
                    spf_pkg::OP_PAGE_ERASE:
                        job_next.op = spf_pkg::SPF_OP_PE;
                    spf_pkg::OP_SUB_ERASE:
                        job_next.op = spf_pkg::SPF_OP_SSE;
                    spf_pkg::OP_SECTOR_ERASE:
                        job_next.op = spf_pkg::SPF_OP_SE;
                    spf_pkg::OP_BULK_ERASE:
                        job_next.op = spf_pkg::SPF_OP_BE;
                    default: job_next.op = spf_pkg::SPF_OP_NONE;
                endcase
                // page write and program need data; all but bulk erase need full address
                if (job_next.op != spf_pkg::SPF_OP_NONE && wen_reg
                    && !busy_reg && st_reg != SPF_ADDR
                    && !(st_reg == SPF_DATA && cnt_reg == 9'h0
                    && (cmd_reg == spf_pkg::OP_PAGE_WRITE
                    || cmd_reg == spf_pkg::OP_PAGE_PROGRAM))
                    && !(prot_hit || (bp != 3'h0
                    && cmd_reg == spf_pkg::OP_BULK_ERASE))) begin
                    jv_next = 1'b1;
                    busy_next = 1'b1;
                    wen_next = 1'b0;
                end
            end
        end
        if (!hr_reg) begin
            st_next = SPF_IDLE;
            oe_next = 1'b0;
            busy_next = 1'b0;
            wen_next = 1'b0;
            jv_next = 1'b0;
        end
        if (!armed_reg && !sel_fall)
            st_next = SPF_IDLE;
        stat_next[0] = busy_next;
        stat_next[1] = wen_next;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_reg <= SPF_IDLE;
            bit_reg <= spf_pkg::BIT_CNT_RST;
            sh_reg <= 8'h00;
            cmd_reg <= 8'h00;
            ab_reg <= 2'h0;
            addr_reg <= '0;
            cnt_reg <= 9'h000;
            out_reg <= 8'h00;
            stat_reg <= spf_pkg::STATUS_RST;
            armed_reg <= 1'b0;
            wen_reg <= 1'b0;
            busy_reg <= 1'b0;
            miso_reg <= 1'b0;
            oe_reg <= 1'b0;
            job_reg <= '0;
            jv_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            cmd_reg <= cmd_next;
            ab_reg <= ab_next;
            addr_reg <= addr_next;
            cnt_reg <= cnt_next;
            out_reg <= out_next;
            stat_reg <= stat_next;
            armed_reg <= armed_next;
            wen_reg <= wen_next;
            busy_reg <= busy_next;
            miso_reg <= miso_next;
            oe_reg <= oe_next;
            job_reg <= job_next;
            jv_reg <= jv_next;
        end
    end

    logic act_reg, stby_reg;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            act_reg <= 1'b0;
            stby_reg <= 1'b1;
        end else begin
            act_reg <= !pin_reg.sel_b && hr_reg;
            stby_reg <= pin_reg.sel_b && !busy_reg;
        end
    end

    assign miso_o = miso_reg;
    assign miso_oe = oe_reg;
    assign active_mode = act_reg;
    assign standby_mode = stby_reg;
    assign write_in_progress = busy_reg;
    assign status_out = stat_reg;
    assign job = job_reg;
    assign job_valid = jv_reg;
    assign raddr = addr_reg;

    a_deselect_hiz: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(pin_reg.sel_b) |=> !oe_reg)
        else $error("output enabled after deselect");
    a_reset_hiz: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !hr_reg |=> !oe_reg && !busy_reg)
        else $error("output enabled in reset mode");
    a_standby_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
        pin_reg.sel_b && !busy_reg |=> stby_reg)
        else $error("standby not shown");
    a_active_sel: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !pin_reg.sel_b && hr_reg |=> act_reg && !stby_reg)
        else $error("active mode not shown");
    a_unarmed_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !armed_reg && !sel_fall |=> st_reg == SPF_IDLE)
        else $error("instruction taken before select edge");
    a_miso_fall: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !fall && !byte_done && st_reg == SPF_OUT |=> $stable(miso_reg))
        else $error("output moved off falling edge");
    a_bit_rise: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !rise && !sel_fall |=> $stable(bit_reg))
        else $error("bit count moved without rising edge");
    a_job_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
        jv_reg |-> busy_reg && stat_reg[0])
        else $error("job without write in progress");
    a_page_limit: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cnt_reg <= 9'h100)
        else $error("more than a page of data");
endmodule
`default_nettype wire

/* File: hdl/spf_pkg.sv */
package spf_pkg;
    localparam int ADDR_W = 20;
    localparam int PAGE_BYTES = 256;
    localparam int PAGES_PER_SUB = 16;
    localparam int SUBS_PER_SECTOR = 16;
    localparam int SECTORS = 16;
    localparam int PAGES_TOTAL = 4096;
    localparam int SECTOR_BIT = 16;
    localparam int SUB_BIT = 12;
    localparam int PAGE_BIT = 8;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h0A;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_PAGE_ERASE = 8'hDB;
    localparam logic [7:0] OP_SUB_ERASE = 8'h20;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
    localparam logic [7:0] OP_BULK_ERASE = 8'hC7;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_WRITE_EN = 8'h06;
    localparam logic [7:0] STATUS_WR_MASK = 8'h9C;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [2:0] BIT_CNT_RST = 3'h0;
    localparam logic [1:0] ADDR_BYTES = 2'h3;
    localparam int FIFO_DEPTH = 32;

    typedef enum logic [2:0] {
        SPF_OP_NONE, SPF_OP_PW, SPF_OP_PP, SPF_OP_PE,
        SPF_OP_SSE, SPF_OP_SE, SPF_OP_BE, SPF_OP_SR
    } spf_op_t;

    typedef struct packed {
        spf_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [8:0] count;
    } spf_job_t;

    typedef struct packed {
        logic sel_b;
        logic sclk;
        logic mosi;
    } spf_pins_t;
endpackage

/* File: tb/serial_paged_flash_front_end_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_paged_flash_front_end_tb;
    logic sys_clk = 1'b0, rst_b = 1'b0, hw_reset_b = 1'b1;
    logic top_lock_n = 1'b1, job_done = 1'b0, wdata_ready = 1'b1;
    logic sel_b, sclk, mosi, miso_o, miso_oe, active_mode, standby_mode;
    logic write_in_progress, job_valid, wdata_valid;
    logic [7:0] status_out, wdata, rdata, q;
    logic [spf_pkg::ADDR_W-1:0] raddr;
    spf_pkg::spf_job_t job, last_job;
    int err_total = 0, n_compared = 0, cyc = 0;
    int n_jobs = 0, n_wdata = 0, busy_cnt = 0, nb;
    logic [7:0] wq [$];
    logic [7:0] rx [4];
    logic [7:0] e_opc [4];
    spf_pkg::spf_op_t e_op [4];
    int e_na [4];

    initial forever #5 sys_clk = ~sys_clk;
    assign rdata = raddr[7:0] ^ 8'h5A;

    spf_front_end spf_front_end_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .sel_b(sel_b), .sclk(sclk), .mosi(mosi), .hw_reset_b(hw_reset_b),
        .top_lock_n(top_lock_n), .miso_o(miso_o), .miso_oe(miso_oe),
        .active_mode(active_mode), .standby_mode(standby_mode),
        .write_in_progress(write_in_progress), .status_out(status_out),
        .job(job), .job_valid(job_valid), .job_done(job_done),
        .wdata(wdata), .wdata_valid(wdata_valid),
        .wdata_ready(wdata_ready), .rdata(rdata), .raddr(raddr));
    spf_master spf_master_inst (.sys_clk(sys_clk), .miso_o(miso_o),
        .miso_oe(miso_oe), .sel_b(sel_b), .sclk(sclk), .mosi(mosi));

    // back end: finishes each job 400 cycles later, sinks page data
    always @(posedge sys_clk) begin
        job_done <= 1'b0;
        cyc++;
        if (job_valid === 1'b1) begin
            n_jobs++;
            last_job = job;
            busy_cnt = 400;
        end else if (busy_cnt > 0) begin
            busy_cnt--;
            if (busy_cnt == 0) job_done <= 1'b1;
        end
        if (wdata_valid === 1'b1 && wdata_ready === 1'b1) begin
            n_wdata++;
            wq.push_back(wdata);
        end
        if (cyc == 95000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] s,
                       input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic seq(input logic [7:0] op, input logic [23:0] a,
                       input int na, input int nd, input logic [7:0] d0);
        logic [7:0] r;
        spf_master_inst.sel();
        spf_master_inst.xfer(op, r);
        for (int i = na - 1; i >= 0; i--) begin
            spf_master_inst.xfer(a[8*i +: 8], r);
        end
        for (int i = 0; i < nd; i++) begin
            spf_master_inst.xfer(d0 + i[7:0], r);
            if (i < 4) rx[i] = r;
        end
        spf_master_inst.desel();
        chk("miso_oe idle", miso_oe, 0);
    endtask
    task automatic wren();
        seq(spf_pkg::OP_WRITE_EN, 24'h0, 0, 0, 8'h00);
    endtask
    task automatic rdsr();
        seq(spf_pkg::OP_READ_STATUS, 24'h0, 0, 1, 8'h00);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (write_in_progress !== 1'b0 && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        chk("idle wait", n < 2000, 1);
        repeat (2) @(posedge sys_clk);
    endtask

    initial begin
        e_opc = '{spf_pkg::OP_PAGE_ERASE, spf_pkg::OP_SUB_ERASE,
                  spf_pkg::OP_SECTOR_ERASE, spf_pkg::OP_BULK_ERASE};
        e_op = '{spf_pkg::SPF_OP_PE, spf_pkg::SPF_OP_SSE,
                 spf_pkg::SPF_OP_SE, spf_pkg::SPF_OP_BE};
        e_na = '{3, 3, 3, 0};
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge sys_clk);
        // no select falling edge yet: this enable must be ignored
        spf_master_inst.xfer(spf_pkg::OP_WRITE_EN, q);
        spf_master_inst.desel();
        chk("standby", standby_mode, 1);
        chk("active idle", active_mode, 0);
        chk("wip idle", write_in_progress, 0);
        rdsr();
        chk("wel ignored", rx[0][1], 0);
        spf_master_inst.sel();
        repeat (4) @(posedge sys_clk);
        chk("active", active_mode, 1);
        chk("standby sel", standby_mode, 0);
        spf_master_inst.desel();
        wren();
        rdsr();
        chk("status wel", rx[0], 8'h02);
        wren();
        seq(spf_pkg::OP_PAGE_WRITE, 24'h012300, 3, 0, 8'h00);
        chk("no job empty", n_jobs, 0);
        wren();
        seq(spf_pkg::OP_PAGE_WRITE, 24'h0ABC00, 3, 256, 8'h00);
        chk("pw job", n_jobs, 1);
        chk("pw op", last_job.op, spf_pkg::SPF_OP_PW);
        chk("pw addr", last_job.addr, 20'hABC00);
        chk("pw count", last_job.count, 9'h100);
        rdsr();
        chk("busy bit", rx[0][0], 1);
        chk("wip", write_in_progress, 1);
        wait_idle();
        chk("pw bytes", n_wdata, 256);
        chk("pw first", wq[0], 8'h00);
        chk("pw last", wq[255], 8'hFF);
        for (int k = 0; k < 4; k++) begin
            nb = n_jobs;
            wren();
            seq(e_opc[k], 24'h050000, e_na[k], 0, 8'h00);
            chk("erase job", n_jobs, nb + 1);
            chk("erase op", last_job.op, e_op[k]);
            if (e_na[k] == 3) chk("erase addr", last_job.addr, 20'h50000);
            wait_idle();
        end
        wren();
        seq(spf_pkg::OP_STATUS_WRITE, 24'h0, 0, 1, 8'h7F);
        wait_idle();
        rdsr();
        chk("status wr", rx[0] & 8'h9C, 8'h1C);
        chk("status out", status_out & 8'h9C, 8'h1C);
        nb = n_jobs;
        wren();
        seq(spf_pkg::OP_PAGE_ERASE, 24'h000100, 3, 0, 8'h00);
        chk("protected", n_jobs, nb);
        wren();
        seq(spf_pkg::OP_STATUS_WRITE, 24'h0, 0, 1, 8'h00);
        wait_idle();
        top_lock_n <= 1'b0;
        nb = n_jobs;
        wren();
        seq(spf_pkg::OP_PAGE_ERASE, 24'h0F0000, 3, 0, 8'h00);
        chk("top locked", n_jobs, nb);
        wren();
        seq(spf_pkg::OP_PAGE_ERASE, 24'h0E0000, 3, 0, 8'h00);
        chk("sector 14 open", n_jobs, nb + 1);
        wait_idle();
        top_lock_n <= 1'b1;
        seq(spf_pkg::OP_READ, 24'h0123FE, 3, 2, 8'h00);
        chk("read 0", rx[0], 8'hFE ^ 8'h5A);
        chk("read 1", rx[1], 8'hFF ^ 8'h5A);
        wdata_ready <= 1'b0;
        nb = n_wdata;
        wren();
        seq(spf_pkg::OP_PAGE_PROGRAM, 24'h000000, 3, 40, 8'h10);
        chk("pp op", last_job.op, spf_pkg::SPF_OP_PP);
        chk("stalled", n_wdata, nb);
        wdata_ready <= 1'b1;
        wait_idle();
        repeat (40) @(posedge sys_clk);
        chk("fifo kept", n_wdata - nb, spf_pkg::FIFO_DEPTH);
        chk("fifo head", wq[nb], 8'h10);
        // idle first: resetting mid-cycle may corrupt data
        spf_master_inst.sel();
        spf_master_inst.xfer(spf_pkg::OP_READ, q);
        for (int i = 0; i < 3; i++) spf_master_inst.xfer(8'h00, q);
        hw_reset_b <= 1'b0;
        spf_master_inst.xfer(8'h00, q);
        chk("reset oe", miso_oe, 0);
        spf_master_inst.desel();
        hw_reset_b <= 1'b1;
        repeat (8) @(posedge sys_clk);
        wren();
        rdsr();
        chk("after reset", rx[0], 8'h02);
        end_sim();
    end
endmodule
`default_nettype wire

/* File: tb/spf_master.sv */
`timescale 1ns/1ps
`default_nettype none
module spf_master #(
    parameter int HALF = 6
) (
    input wire logic sys_clk,
    input wire logic miso_o,
    input wire logic miso_oe,
    output logic sel_b,
    output logic sclk,
    output logic mosi
);
    logic miso_last = 1'b0;
    logic miso_w;
    // released line shows the inverse of its last driven value
    assign miso_w = miso_oe ? miso_o : ~miso_last;
    always_ff @(posedge sys_clk) begin
        if (miso_oe) miso_last <= miso_o;
    end
    // select starts low so the first select carries no falling edge
    initial begin
        sel_b = 1'b0;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    task automatic sel();
        sel_b <= 1'b0;
        repeat (HALF) @(posedge sys_clk);
    endtask
    task automatic desel();
        repeat (HALF) @(posedge sys_clk);
        sel_b <= 1'b1;
        mosi <= ~mosi;
        repeat (2 * HALF) @(posedge sys_clk);
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            @(posedge sys_clk);
            mosi <= d[i];
            repeat (HALF) @(posedge sys_clk);
            q[i] = miso_w;
            sclk <= 1'b1;
            repeat (HALF) @(posedge sys_clk);
            sclk <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire
